//--- bench/serial_flash_command_timing_tb_top.sv
// bench for controller and device joined over the link
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module serial_flash_command_timing_tb_top;
    logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, deep_sleep;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [7:0] state_word, r;
    int error_cnt = 0, tests_run = 0, n;
    logic [7:0] ops [4] = '{8'h20, 8'hd8, 8'h60, 8'hc7};
    int lens [4] = '{300, 300, 400, 400};
    always #25 clk = ~clk;
    sfc_link_if link ();
    // short job counts keep the run small
    // power-up delay keeps its true length; state write timing is not exercised
    sfc_flash_dev #(.PROG_CYC(500), .SECT_CYC(300), .BULK_CYC(400),
        .SLEEP_CYC(30), .WAKE_CYC(30)) sfc_flash_dev_i (.clk(clk),
        .reset(reset), .link(link.dev), .state_word(state_word), .deep_sleep(deep_sleep));
    sfc_flash_host sfc_flash_host_i (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link.host));
    sfc_link_monitor sfc_link_monitor_i (.clk(clk), .reset(reset), .sck(link.sck),
        .cs_n(link.cs_n), .mosi(link.mosi), .guard_n(link.guard_n), .miso(link.miso),
        .miso_oe(link.miso_oe), .miso_line(link.miso_line));
    // --------------------
    // bus and link tasks
    // --------------------
    task tally_and_finish;
        $display("errors=%0d checks=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task fail_to;
        `CHK(1'b0, 1'b1)
        tally_and_finish();
    endtask : fail_to
    task rdy;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) fail_to();
    endtask : rdy
    task ahb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {28'h0, a};
        hwrite <= w;
        hsize <= 3'b010;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask : ahb
    task xb(input logic [7:0] t);
        int k;
        ahb(1'b1, 4'h4, {24'h0, t});
        k = 0;
        do begin
            ahb(1'b0, 4'hc, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 300);
        if (k >= 300) fail_to();
        ahb(1'b0, 4'h8, 32'h0);
        r = rd[7:0];
    endtask : xb
    // guard pin kept high, half period 4
    task seq(input logic [7:0] op, input logic adr, input logic [7:0] a, input int nd);
        ahb(1'b1, 4'h0, 32'h0403);
        xb(op);
        if (adr) begin
            xb(8'h00);
            xb(8'h00);
            xb(a);
        end
        repeat (nd) xb(8'h5a);
        ahb(1'b1, 4'h0, 32'h0402);
    endtask : seq
    task wait_for(input logic s, input logic lvl, input int lim);
        int k;
        k = 0;
        while (((s ? deep_sleep : state_word[0]) !== lvl) && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (k >= lim) fail_to();
    endtask : wait_for
    // --------------------
    // scenarios
    // --------------------
    task t_puw;
        seq(8'h06, 1'b0, 8'h00, 0);
        repeat (6) @(posedge clk);
        `CHK(state_word[1], 1'b0)
    endtask : t_puw
    task t_init;
        `CHK(state_word, 8'h00)
        `CHK(deep_sleep, 1'b0)
        seq(8'h05, 1'b0, 8'h00, 1);
        `CHK(r, 8'h00)
        seq(8'h03, 1'b1, 8'h10, 1);
        `CHK(r, 8'hff)
    endtask : t_init
    task t_prog;
        repeat (sfc_pkg::PUW_CYC) @(posedge clk);
        seq(8'h06, 1'b0, 8'h00, 0);
        repeat (6) @(posedge clk);
        `CHK(state_word[1], 1'b1)
        seq(8'h02, 1'b1, 8'h10, 1);
        repeat (6) @(posedge clk);
        `CHK(state_word[0], 1'b1)
        seq(8'h05, 1'b0, 8'h00, 1);
        `CHK(r[0], 1'b1)
        wait_for(1'b0, 1'b0, 600);
        seq(8'h03, 1'b1, 8'h10, 1);
        `CHK(r, 8'h5a)
    endtask : t_prog
    task t_wipe;
        for (int i = 0; i < 4; i++) begin
            seq(8'h06, 1'b0, 8'h00, 0);
            seq(ops[i], i < 2, 8'h10, 0);
            wait_for(1'b0, 1'b1, 20);
            n = 0;
            while (state_word[0] === 1'b1 && n < 2000) begin
                @(negedge clk);
                n++;
            end
            `CHK(n, lens[i])
            seq(8'h03, 1'b1, 8'h10, 1);
            `CHK(r, 8'hff)
        end
    endtask : t_wipe
    task t_sleep;
        seq(8'hb9, 1'b0, 8'h00, 0);
        wait_for(1'b1, 1'b1, 40);
        `CHK(deep_sleep, 1'b1)
        // asleep: state read ignored, line stays pulled high
        seq(8'h05, 1'b0, 8'h00, 1);
        `CHK(r, 8'hff)
        seq(8'hab, 1'b0, 8'h00, 0);
        wait_for(1'b1, 1'b0, 40);
        `CHK(deep_sleep, 1'b0)
        seq(8'h05, 1'b0, 8'h00, 1);
        `CHK(r, 8'h00)
    endtask : t_sleep
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_puw();
        t_init();
        t_prog();
        t_wipe();
        t_sleep();
        tally_and_finish();
    end
endmodule : serial_flash_command_timing_tb_top

//--- bench/sfc_link_monitor.sv
// link checker between controller and device ends
`timescale 1ns/1ps
module sfc_link_monitor (
    input logic clk,
    input logic reset,
    input logic sck,
    input logic cs_n,
    input logic mosi,
    input logic guard_n,
    input logic miso,
    input logic miso_oe,
    input logic miso_line
);
    // --------------------
    // link properties
    // --------------------
    property p_rst_idle;
        @(posedge clk) disable iff (reset) $fell(reset) |-> cs_n && !sck && !miso_oe;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
    // half period floor of 4 clk
    property p_sck_hi;
        @(posedge clk) disable iff (reset) $rose(sck) |=> sck [*3];
    endproperty
    a_sck_hi: assert property (p_sck_hi) else $error("sck high phase short");
    property p_sck_lo;
        @(posedge clk) disable iff (reset) $fell(sck) |=> (!sck) [*3];
    endproperty
    a_sck_lo: assert property (p_sck_lo) else $error("sck low phase short");
    property p_mosi;
        @(posedge clk) disable iff (reset) sck && $past(sck) |-> $stable(mosi);
    endproperty
    a_mosi: assert property (p_mosi) else $error("mosi moved while sck high");
    property p_cs_sck;
        @(posedge clk) disable iff (reset) $rose(cs_n) |-> !sck;
    endproperty
    a_cs_sck: assert property (p_cs_sck) else $error("deselect with sck high");
    property p_cs_fall;
        @(posedge clk) disable iff (reset) $fell(cs_n) |-> !sck;
    endproperty
    a_cs_fall: assert property (p_cs_fall) else $error("select with sck high");
    // sync latency leaves a few clk before release
    property p_oe_off;
        @(posedge clk) disable iff (reset) $rose(cs_n) |-> ##[0:5] !miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output kept on after deselect");
    property p_oe_sel;
        @(posedge clk) disable iff (reset) $rose(miso_oe) |-> !cs_n;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("output on while deselected");
endmodule : sfc_link_monitor

//--- verilog/sfc_flash_dev.sv
// serial flash device end: command decode, timed jobs, power states
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps

module sfc_flash_dev #(
    parameter int unsigned DEPTH = 256,
    parameter int unsigned PROG_CYC = sfc_pkg::PROG_CYC,
    parameter int unsigned SECT_CYC = sfc_pkg::SECT_CYC,
    parameter int unsigned BULK_CYC = sfc_pkg::BULK_CYC,
    parameter int unsigned STAT_CYC = sfc_pkg::STAT_CYC,
    parameter int unsigned SLEEP_CYC = sfc_pkg::SLEEP_CYC,
    parameter int unsigned WAKE_CYC = sfc_pkg::WAKE_CYC,
    parameter int unsigned PUW_CYC = sfc_pkg::PUW_CYC,
    // identification values are arbitrary
    parameter logic [7:0] MAKER_ID = 8'h3c,
    parameter logic [7:0] TYPE_ID = 8'h7e,
    parameter logic [7:0] CAP_ID = 8'h11,
    parameter logic [7:0] PART_ID = 8'h47
) (
    input logic clk,
    input logic reset,
    sfc_link_if.dev link,
    output logic [7:0] state_word,
    output logic deep_sleep
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic sck_m, sck_s, sck_p, cs_m, cs_s, cs_p, si_m, si_s, gd_m, gd_s;
        logic [2:0] bitc;
        logic [2:0] nb;
        logic [7:0] sh;
        logic [7:0] op;
        logic [7:0] out;
        logic [7:0] pend;
        logic [23:0] addr;
        logic oe, dout, write_unlock_flag, lock, fail, busy;
        logic [2:0] guard;
        sfc_pkg::sfc_job_e job;
        sfc_pkg::sfc_pwr_e pwr;
        logic [31:0] tmr;
        logic [31:0] ptmr;
        logic [31:0] puw;
        logic [DEPTH-1:0][7:0] mem;
    } sfc_dev_s;

    sfc_dev_s r, n;
    logic rise, fall, whole, wr_ok, live;
    logic [7:0] bytev, stat, nxt;
    logic [2:0] dnb;
    logic [AW-1:0] idx;

    // ------------------------------------------------------------
    // byte on which read data starts, zero for no output
    // ------------------------------------------------------------
    function automatic logic [2:0] data_nb(input logic [7:0] op);
        if (op == sfc_pkg::OP_STATE_READ || op == sfc_pkg::OP_JEDEC_READ) begin
            return 3'd1;
        end else if (op == sfc_pkg::OP_FAST_READ) begin
            return 3'd5;
        end else if (op == sfc_pkg::OP_READ || op == sfc_pkg::OP_WAKE
                     || op == sfc_pkg::OP_MAKER_READ) begin
            return 3'd4;
        end
        return 3'd0;
    endfunction : data_nb

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.sck_m = link.sck;
        n.sck_s = r.sck_m;
        n.sck_p = r.sck_s;
        n.cs_m = link.cs_n;
        n.cs_s = r.cs_m;
        n.cs_p = r.cs_s;
        n.si_m = link.mosi;
        n.si_s = r.si_m;
        n.gd_m = link.guard_n;
        n.gd_s = r.gd_m;
        rise = ~r.cs_s & r.sck_s & ~r.sck_p;
        fall = ~r.cs_s & ~r.sck_s & r.sck_p;
        bytev = {r.sh[6:0], r.si_s};
        stat = {r.lock, r.fail, 1'b0, r.guard, r.write_unlock_flag, r.busy};
        wr_ok = (r.puw == 32'h0) & ~r.busy & (r.pwr == sfc_pkg::PWR_AWAKE);
        live = (r.op == sfc_pkg::OP_WAKE)
            | ((r.pwr == sfc_pkg::PWR_AWAKE) & (~r.busy | (r.op == sfc_pkg::OP_STATE_READ)));
        dnb = data_nb(r.op);
        idx = r.addr[AW-1:0];
        whole = (r.bitc == 3'd0);
        nxt = 8'h00;

        // select: restart framing
        if (~r.cs_s & r.cs_p) begin
            n.bitc = 3'd0;
            n.nb = 3'd0;
            n.oe = 1'b0;
        end

        if (rise) begin
            n.sh = bytev;
            n.bitc = r.bitc + 3'd1;
            if (r.bitc == 3'd7) begin
                if (r.nb != 3'd7) begin
                    n.nb = r.nb + 3'd1;
                end
                if (r.nb == 3'd0) begin
                    n.op = bytev;
                    if (data_nb(bytev) == 3'd1 && r.pwr == sfc_pkg::PWR_AWAKE
                        && (~r.busy || bytev == sfc_pkg::OP_STATE_READ)) begin
                        n.oe = 1'b1;
                    end
                end else if (r.nb <= 3'd3) begin
                    n.addr = {r.addr[15:0], bytev};
                end
                if (r.nb == 3'd1) begin
                    n.pend = bytev;
                end
                // program into the array as bytes arrive, wrapping in the page
                if (r.nb >= 3'd4 && r.op == sfc_pkg::OP_PAGE_WRITE && wr_ok && r.write_unlock_flag
                    && r.guard == 3'd0) begin
                    n.mem[idx] = r.mem[idx] & bytev;
                    n.addr[7:0] = r.addr[7:0] + 8'h01;
                end
            end
        end

        if (fall && live && dnb != 3'd0) begin
            if (r.bitc == 3'd7 && r.nb == dnb - 3'd1 && dnb != 3'd1) begin
                n.oe = 1'b1;
            end
            if (whole && r.nb >= dnb) begin
                if (r.op == sfc_pkg::OP_STATE_READ) begin
                    nxt = stat;
                end else if (r.op == sfc_pkg::OP_JEDEC_READ) begin
                    nxt = (r.nb == 3'd1) ? MAKER_ID : (r.nb == 3'd2) ? TYPE_ID
                        : (r.nb == 3'd3) ? CAP_ID : 8'h00;
                end else if (r.op == sfc_pkg::OP_WAKE) begin
                    nxt = PART_ID;
                end else if (r.op == sfc_pkg::OP_MAKER_READ) begin
                    nxt = (r.addr[0] ^ r.nb[0]) ? PART_ID : MAKER_ID;
                end else begin
                    nxt = r.mem[idx];
                    n.addr = r.addr + 24'h000001;
                end
                n.oe = 1'b1;
                n.dout = nxt[7];
                n.out = {nxt[6:0], 1'b0};
            end else if (r.oe) begin
                n.dout = r.out[7];
                n.out = {r.out[6:0], 1'b0};
            end
        end

        // internal job timer; only runs while busy
        if (r.busy) begin
            if (r.tmr == 32'h0) begin
                n.busy = 1'b0;
                n.write_unlock_flag = 1'b0;
                n.job = sfc_pkg::JOB_NONE;
                unique case (r.job)
                    sfc_pkg::JOB_NONE: ;
                    sfc_pkg::JOB_PROG: n.fail = (r.guard != 3'd0);
                    sfc_pkg::JOB_WIPE: begin
                        if (r.guard != 3'd0) begin
                            n.fail = 1'b1;
                        end else begin
                            n.mem = {DEPTH{sfc_pkg::ERASED}};
                        end
                    end
                    sfc_pkg::JOB_STAT: begin
                        n.lock = r.pend[7];
                        n.guard = r.pend[4:2];
                    end
                endcase
            end else begin
                n.tmr = r.tmr - 32'h1;
            end
        end

        unique case (r.pwr)
            sfc_pkg::PWR_AWAKE: ;
            sfc_pkg::PWR_SLEEP: ;
            sfc_pkg::PWR_ENTER: begin
                if (r.ptmr == 32'h0) begin
                    n.pwr = sfc_pkg::PWR_SLEEP;
                end else begin
                    n.ptmr = r.ptmr - 32'h1;
                end
            end
            sfc_pkg::PWR_WAKE: begin
                if (r.ptmr == 32'h0) begin
                    n.pwr = sfc_pkg::PWR_AWAKE;
                end else begin
                    n.ptmr = r.ptmr - 32'h1;
                end
            end
        endcase

        if (r.puw != 32'h0) begin
            n.puw = r.puw - 32'h1;
        end

        // deselect: commands act on the rising chip select
        if (r.cs_s & ~r.cs_p) begin
            n.oe = 1'b0;
            if (r.op == sfc_pkg::OP_WRITE_UNLOCK && r.nb == 3'd1 && whole && wr_ok) begin
                n.write_unlock_flag = 1'b1;
            end else if (r.op == sfc_pkg::OP_WRITE_LOCK && r.nb == 3'd1 && whole && ~r.busy) begin
                n.write_unlock_flag = 1'b0;
            end else if (wr_ok && r.write_unlock_flag && whole) begin
                if (r.op == sfc_pkg::OP_PAGE_WRITE && r.nb >= 3'd5) begin
                    n.busy = 1'b1;
                    n.fail = 1'b0;
                    n.job = sfc_pkg::JOB_PROG;
                    n.tmr = 32'(PROG_CYC - 1);
                end else if ((r.op == sfc_pkg::OP_BLOCK_WIPE_A
                              || r.op == sfc_pkg::OP_BLOCK_WIPE_B) && r.nb == 3'd4) begin
                    n.busy = 1'b1;
                    n.fail = 1'b0;
                    n.job = sfc_pkg::JOB_WIPE;
                    n.tmr = 32'(SECT_CYC - 1);
                end else if ((r.op == sfc_pkg::OP_BULK_WIPE_A
                              || r.op == sfc_pkg::OP_BULK_WIPE_B) && r.nb == 3'd1) begin
                    n.busy = 1'b1;
                    n.fail = 1'b0;
                    n.job = sfc_pkg::JOB_WIPE;
                    n.tmr = 32'(BULK_CYC - 1);
                end else if (r.op == sfc_pkg::OP_STATE_WRITE && r.nb == 3'd2
                             && ~(r.lock & ~r.gd_s)) begin
                    n.busy = 1'b1;
                    n.fail = 1'b0;
                    n.job = sfc_pkg::JOB_STAT;
                    n.tmr = 32'(STAT_CYC - 1);
                end
            end
            if (r.op == sfc_pkg::OP_DEEP_SLEEP && r.nb == 3'd1 && whole && ~r.busy
                && r.pwr == sfc_pkg::PWR_AWAKE) begin
                n.pwr = sfc_pkg::PWR_ENTER;
                n.ptmr = 32'(SLEEP_CYC - 1);
            end else if (r.op == sfc_pkg::OP_WAKE && whole && r.nb != 3'd0
                         && (r.pwr == sfc_pkg::PWR_SLEEP || r.pwr == sfc_pkg::PWR_ENTER)) begin
                n.pwr = sfc_pkg::PWR_WAKE;
                n.ptmr = 32'(WAKE_CYC - 1);
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.sck_m <= 1'b0;
            r.cs_m <= 1'b1;
            r.cs_s <= 1'b1;
            r.cs_p <= 1'b1;
            r.gd_m <= 1'b1;
            r.gd_s <= 1'b1;
            r.pwr <= sfc_pkg::PWR_AWAKE;
            r.write_unlock_flag <= 1'b0;
            r.lock <= sfc_pkg::STATE_RST[7];
            r.fail <= sfc_pkg::STATE_RST[6];
            r.guard <= sfc_pkg::STATE_RST[4:2];
            r.puw <= 32'(PUW_CYC - 1);
            r.mem <= {DEPTH{sfc_pkg::ERASED}};
        end else begin
            r <= n;
        end
    end

    assign link.miso = r.dout;
    assign link.miso_oe = r.oe;
    assign state_word = {r.lock, r.fail, 1'b0, r.guard, r.write_unlock_flag, r.busy};
    assign deep_sleep = (r.pwr == sfc_pkg::PWR_SLEEP);

endmodule : sfc_flash_dev

//--- verilog/sfc_flash_host.sv
// serial flash controller end: ahb-lite registers, byte shifter
`timescale 1ns/1ps
module sfc_flash_host (
    input logic clk,
    input logic reset,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    sfc_link_if.host link
);
    typedef struct packed {
        logic [3:0] a;
        logic wr, val;
        logic [31:0] rdata;
        logic sel, guard;
        logic [7:0] div;
        logic busy, sck, mosi, first, mm, ms;
        logic [2:0] bits;
        logic [7:0] tx, rx, op, hc;
    } sfc_host_s;

    sfc_host_s r, n;
    logic [7:0] half, lim;
    logic tick;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.mm = link.miso_line;
        n.ms = r.mm;
        // the sync delay on both ends sets a floor on the half period
        lim = (r.op == sfc_pkg::OP_READ) ? 8'(sfc_pkg::HALF_READ) : 8'(sfc_pkg::HALF_FAST);
        half = (r.div > lim) ? r.div : lim;
        if (half < sfc_pkg::HALF_LAT) begin
            half = sfc_pkg::HALF_LAT;
        end
        tick = r.busy && (r.hc + 8'h01 >= half);

        // bus address phase; read data is ready for the data phase
        n.val = hsel & hready & htrans[1];
        n.a = haddr[3:0];
        n.wr = hwrite;
        if (hsel & hready & htrans[1] & ~hwrite) begin
            unique case (haddr[3:0])
                sfc_pkg::REG_CTRL: n.rdata = {16'h0, r.div, 6'h0, r.guard, r.sel};
                sfc_pkg::REG_RX: n.rdata = {24'h0, r.rx};
                sfc_pkg::REG_STAT: n.rdata = {31'h0, r.busy};
                default: n.rdata = 32'h0;
            endcase
        end

        // bus data phase for writes
        if (r.val && r.wr) begin
            if (r.a == sfc_pkg::REG_CTRL) begin
                n.sel = hwdata[sfc_pkg::CTRL_SEL_BIT];
                n.guard = hwdata[sfc_pkg::CTRL_GUARD_BIT];
                n.div = hwdata[sfc_pkg::CTRL_DIV_LSB +: 8];
            end else if (r.a == sfc_pkg::REG_TX && r.sel && ~r.busy) begin
                // any opcode byte goes out as written
                n.busy = 1'b1;
                n.tx = hwdata[7:0];
                n.mosi = hwdata[7];
                n.bits = 3'd0;
                n.hc = 8'h00;
                n.first = 1'b0;
                if (r.first) begin
                    n.op = hwdata[7:0];
                end
            end
        end
        if (~r.sel) begin
            n.first = 1'b1;
        end

        // shifting: mosi changes on the falling edge
        if (r.busy) begin
            n.hc = tick ? 8'h00 : r.hc + 8'h01;
            if (tick && ~r.sck) begin
                n.sck = 1'b1;
            end else if (tick) begin
                // sampled late in the high phase to absorb the device's latency
                n.rx = {r.rx[6:0], r.ms};
                n.sck = 1'b0;
                n.bits = r.bits + 3'd1;
                n.tx = {r.tx[6:0], 1'b0};
                n.mosi = r.tx[6];
                if (r.bits == 3'd7) begin
                    n.busy = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.guard <= 1'b1;
            r.div <= sfc_pkg::DIV_RST;
            r.first <= 1'b1;
            r.mm <= 1'b1;
            r.ms <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    assign link.sck = r.sck;
    assign link.cs_n = ~r.sel;
    assign link.mosi = r.mosi;
    assign link.guard_n = r.guard;

endmodule : sfc_flash_host

//--- verilog/sfc_link_if.sv
// serial flash link between controller and device
`timescale 1ns/1ps
interface sfc_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic guard_n;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // pulled high while nobody drives the output line
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (input sck, input cs_n, input mosi, input guard_n, output miso, output miso_oe);
    modport host (output sck, output cs_n, output mosi, output guard_n, input miso_line);
endinterface : sfc_link_if

//--- verilog/sfc_pkg.sv
// shared constants and types for the serial flash link ends
package sfc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned T_PROG_MS = 3;
    localparam int unsigned T_SECT_S = 1;
    localparam int unsigned T_BULK_S = 32;
    localparam int unsigned T_STAT_MS = 90;
    localparam int unsigned T_SLEEP_MS = 3;
    localparam int unsigned T_WAKE_MS = 30;
    localparam int unsigned T_PUW_MS = 1;
    localparam int unsigned PROG_CYC = T_PROG_MS * (CLK_HZ / 1000);
    localparam int unsigned SECT_CYC = T_SECT_S * CLK_HZ;
    localparam int unsigned BULK_CYC = T_BULK_S * CLK_HZ;
    localparam int unsigned STAT_CYC = T_STAT_MS * (CLK_HZ / 1000);
    localparam int unsigned SLEEP_CYC = T_SLEEP_MS * (CLK_HZ / 1000);
    localparam int unsigned WAKE_CYC = T_WAKE_MS * (CLK_HZ / 1000);
    localparam int unsigned PUW_CYC = T_PUW_MS * (CLK_HZ / 1000);
    localparam int unsigned F_FAST_HZ = 50000000;
    localparam int unsigned F_READ_HZ = 20000000;
    localparam int unsigned HALF_FAST = (CLK_HZ + 2 * F_FAST_HZ - 1) / (2 * F_FAST_HZ);
    localparam int unsigned HALF_READ = (CLK_HZ + 2 * F_READ_HZ - 1) / (2 * F_READ_HZ);
    localparam logic [7:0] HALF_LAT = 8'h04;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
    localparam logic [7:0] OP_JEDEC_READ = 8'h9f;
    localparam logic [7:0] OP_STATE_READ = 8'h05;
    localparam logic [7:0] OP_STATE_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_BLOCK_WIPE_A = 8'h20;
    localparam logic [7:0] OP_BLOCK_WIPE_B = 8'hd8;
    localparam logic [7:0] OP_BULK_WIPE_A = 8'h60;
    localparam logic [7:0] OP_BULK_WIPE_B = 8'hc7;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE = 8'hab;
    localparam logic [7:0] OP_MAKER_READ = 8'h90;

    // ------------------------------------------------------------
    // device reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] STATE_RST = 8'h00;

    // ------------------------------------------------------------
    // controller registers
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TX = 4'h4;
    localparam logic [3:0] REG_RX = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hc;
    localparam int unsigned CTRL_SEL_BIT = 0;
    localparam int unsigned CTRL_GUARD_BIT = 1;
    localparam int unsigned CTRL_DIV_LSB = 8;
    localparam logic [7:0] DIV_RST = 8'h04;

    typedef enum logic [1:0] {
        JOB_NONE = 2'b00,
        JOB_PROG = 2'b01,
        JOB_WIPE = 2'b10,
        JOB_STAT = 2'b11
    } sfc_job_e;

    typedef enum logic [1:0] {
        PWR_AWAKE = 2'b00,
        PWR_ENTER = 2'b01,
        PWR_SLEEP = 2'b10,
        PWR_WAKE = 2'b11
    } sfc_pwr_e;

endpackage : sfc_pkg
